// file: trc_pkg.sv
// Shared constants and types for the tape read record control block.
package trc_pkg;

  // Clock period and the timing figures, each with its derived count.
  localparam int  CLK_NS       = 100;
  localparam int  T_GAP_US     = 80;
  localparam int  T_CHK_US     = 133;
  localparam real T_START_MS   = 1.0;
  localparam real T_RD_STOP_MS = 2.0;
  localparam real T_BK_STOP_MS = 4.5;
  localparam real T_HOLD_MS    = 200.0;
  localparam real T_FM_MS      = 40.0;
  localparam int  GAP_CYC      = (T_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int  CHK_CYC      = (T_CHK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int  START_CYC    = int'($ceil(T_START_MS * 1.0e6 / CLK_NS));
  localparam int  RD_STOP_CYC  = int'($ceil(T_RD_STOP_MS * 1.0e6 / CLK_NS));
  localparam int  BK_STOP_CYC  = int'($ceil(T_BK_STOP_MS * 1.0e6 / CLK_NS));
  localparam int  HOLD_CYC     = int'($ceil(T_HOLD_MS * 1.0e6 / CLK_NS));
  localparam int  FM_CYC       = int'($ceil(T_FM_MS * 1.0e6 / CLK_NS));

  // Data path geometry.
  localparam int  WORD_W       = 48;
  localparam int  CHAR_W       = 6;
  localparam int  FIFO_DEPTH   = 8;
  localparam int  CNT_W        = 21;
  localparam int  GAP_W        = 11;

  // File mark character and the word loaded for its write.
  localparam logic [5:0]  FM_CHAR = 6'h0f;
  localparam logic [47:0] FM_WORD = 48'h00000000000f;

  // Sense codes presented with a sense query.
  localparam logic [2:0] SNS_READY = 3'h0;
  localparam logic [2:0] SNS_PAR   = 3'h2;
  localparam logic [2:0] SNS_LEN   = 3'h4;
  localparam logic [2:0] SNS_EOF   = 3'h6;

  // Channel numbers.
  localparam int CH_IN  = 0;
  localparam int CH_OUT = 1;

  // Per channel sequencer states.
  typedef enum logic [2:0] {
    TRC_IDLE    = 3'b000,
    TRC_START   = 3'b001,
    TRC_RUN     = 3'b010,
    TRC_STOP    = 3'b011,
    TRC_HOLD    = 3'b100,
    TRC_FMSTART = 3'b101,
    TRC_FMCHAR  = 3'b110,
    TRC_FMGAP   = 3'b111
  } trc_st_t;

  // Character stream toward the tape write path.
  typedef struct packed {
    logic       valid;
    logic [5:0] data;
  } trc_char_t;

endpackage : trc_pkg

// file: trc_top.sv
// Word FIFO and the read record, file mark and backspace sequencer.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous word FIFO with valid and ready on both sides.
module trc_fifo #(
  parameter int W = 48,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  logic          wr, rd;

  // Full and empty come straight from the occupancy count.
  assign s_ready = (cnt_q != (AW+1)'(D));
  assign m_valid = (cnt_q != '0);
  assign m_data  = mem[rp_q];
  assign wr      = s_valid & s_ready;
  assign rd      = m_valid & m_ready;

  // Pointers wrap by explicit compare so a depth that is no power of two works.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  // Storage needs no reset; it is only read while the count says valid.
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_q] <= s_data;
    end
  end
endmodule // trc_fifo

////////////////////////////////////////////////////////////////////////////////
module trc_top #(
  parameter int START_CYC   = trc_pkg::START_CYC,
  parameter int RD_STOP_CYC = trc_pkg::RD_STOP_CYC,
  parameter int BK_STOP_CYC = trc_pkg::BK_STOP_CYC,
  parameter int HOLD_CYC    = trc_pkg::HOLD_CYC,
  parameter int FM_CYC      = trc_pkg::FM_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        read_sel,
  input  wire logic [1:0]  bksp_sel,
  input  wire logic        fmark_sel,
  input  wire logic [1:0]  intr_sel,
  input  wire logic        rd_char_valid,
  input  wire logic [5:0]  char_register,
  input  wire logic        reply_char_valid,
  input  wire logic [1:0]  parity_err,
  input  wire logic        eof_detect,
  input  wire logic        eot_detect,
  input  wire logic        data_resume,
  input  wire logic        in_buf_active,
  input  wire logic [1:0]  sense_req,
  input  wire logic [2:0]  sense_code,
  output logic [47:0]      input_word_buffer,
  output logic             data_ready,
  output logic             sense_resp,
  output logic [1:0]       tape_motion,
  output logic [1:0]       tape_reverse,
  output logic [1:0]       chan_busy,
  output logic [1:0]       intr_out,
  output logic             write_current_en,
  output trc_pkg::trc_char_t wr_char,
  output logic             syn_buf_active,
  output logic             syn_out_ready
);
  import trc_pkg::*;

  // All state of the block apart from the word FIFO in one record.
  typedef struct packed {
    trc_st_t [1:0]         st;
    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0][GAP_W-1:0] gap;
    logic [1:0][1:0]       nch;
    logic [1:0]            eor;
    logic [1:0]            bksp;
    logic [1:0]            ien;
    logic [1:0]            irq;
    logic [1:0]            len;
    logic [1:0]            par;
    logic [1:0]            busy;
    logic [1:0]            srq_m;
    logic [1:0]            srq;
    logic [1:0]            srq_p;
    logic                  rd_op;
    logic [2:0]            pos;
    logic                  full;
    logic [47:0]           asm;
    logic                  pend;
    logic [5:0]            chr;
    logic                  flush;
    logic                  eof;
    logic                  eot;
    logic                  rdy;
    logic [47:0]           ibuf;
    logic                  res_m;
    logic                  res;
    logic                  res_p;
    logic                  act_m;
    logic                  act;
    logic                  fm;
    logic [2:0]            slot;
    logic [47:0]           oword;
    trc_char_t             wch;
  } trc_state_t;

  trc_state_t  s_q, s_d;
  logic        f_in_v, f_in_rdy, f_out_v, f_out_rdy;
  logic [47:0] f_in_d, f_out_d;
  logic [1:0]  cv_ch;

  // Words pass through an eight deep FIFO between assembly and the buffer.
  trc_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .clk     (clk),
    .reset   (reset),
    .s_valid (f_in_v),
    .s_ready (f_in_rdy),
    .s_data  (f_in_d),
    .m_valid (f_out_v),
    .m_ready (f_out_rdy),
    .m_data  (f_out_d)
  );

  assign f_out_rdy = ~s_q.rdy;
  assign cv_ch     = {reply_char_valid, rd_char_valid};

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block.
  always_comb begin
    logic       cv;
    logic [5:0] cd;
    logic       go;
    cv     = 1'b0;
    cd     = '0;
    go     = 1'b0;
    s_d    = s_q;
    f_in_v = 1'b0;
    f_in_d = s_q.asm;
    s_d.wch = '0;

    // Sense, resume and buffer-active pins pass two flops; sense and resume add a third so their edges are seen.
    s_d.srq_m = sense_req;
    s_d.srq   = s_q.srq_m;
    s_d.srq_p = s_q.srq;
    s_d.res_m = data_resume;
    s_d.res   = s_q.res_m;
    s_d.res_p = s_q.res;
    s_d.act_m = in_buf_active;
    s_d.act   = s_q.act_m;

    // Each channel runs its own sequencer so reads and writes never wait.
    for (int c = 0; c < 2; c++) begin
      s_d.busy[c] = (s_q.st[c] != TRC_IDLE);
      // Interrupt fires when busy drops; the host arms it while busy.
      if (s_q.busy[c] && s_q.st[c] == TRC_IDLE && s_q.ien[c]) begin
        s_d.irq[c] = 1'b1;
        s_d.ien[c] = 1'b0;
      end else if (s_q.srq[c] && !s_q.srq_p[c] &&
                   sense_code == SNS_READY) begin
        s_d.irq[c] = 1'b0;
      end
      // An arm in the cycle of a firing wins, so it is never lost.
      if (intr_sel[c]) begin
        s_d.ien[c] = 1'b1;
      end
      if (s_q.st[c] != TRC_IDLE && parity_err[c]) begin
        s_d.par[c] = 1'b1;
      end
      case (s_q.st[c])
        TRC_IDLE: begin
          go = bksp_sel[c] | ((c == CH_IN) ? read_sel : fmark_sel);
          if (go) begin
            // A new operation wipes the conditions of the previous one.
            s_d.len[c]  = 1'b0;
            s_d.par[c]  = 1'b0;
            s_d.eor[c]  = 1'b0;
            s_d.bksp[c] = bksp_sel[c];
            s_d.cnt[c]  = CNT_W'(START_CYC);
            s_d.st[c]   = TRC_START;
            if (c == CH_IN) begin
              s_d.rd_op = ~bksp_sel[c];
              s_d.eof   = 1'b0;
              s_d.pos   = '0;
              s_d.full  = 1'b0;
              s_d.asm   = '0;
            end else begin
              s_d.eot = 1'b0;
            end
            if (c == CH_OUT && !bksp_sel[c]) begin
              s_d.fm    = 1'b1;
              s_d.oword = FM_WORD;
              s_d.cnt[c] = CNT_W'(FM_CYC);
              s_d.st[c] = TRC_FMSTART;
            end
          end
        end
        TRC_START: begin
          s_d.cnt[c] = s_q.cnt[c] - 1'b1;
          if (s_q.cnt[c] == '0) begin
            s_d.nch[c] = '0;
            s_d.gap[c] = GAP_W'(GAP_CYC);
            s_d.st[c]  = TRC_RUN;
          end
        end
        TRC_RUN: begin
          // The gap timer restarts on every character once two are seen.
          if (cv_ch[c]) begin
            s_d.gap[c] = GAP_W'(GAP_CYC);
            if (s_q.nch[c] != 2'd2) begin
              s_d.nch[c] = s_q.nch[c] + 1'b1;
            end
          end else if (s_q.nch[c] == 2'd2) begin
            s_d.gap[c] = s_q.gap[c] - 1'b1;
            if (s_q.gap[c] == '0) begin
              s_d.eor[c] = 1'b1;
              s_d.st[c]  = TRC_STOP;
              s_d.cnt[c] = (c == CH_IN) ? CNT_W'(RD_STOP_CYC)
                                        : CNT_W'(BK_STOP_CYC);
              if (c == CH_IN) begin
                s_d.flush = s_q.rd_op;
                if (s_q.pos != '0 || (s_q.rd_op && !s_q.act)) begin
                  s_d.len[c] = 1'b1;
                end
              end
            end
          end
        end
        TRC_STOP: begin
          s_d.cnt[c] = s_q.cnt[c] - 1'b1;
          if (s_q.cnt[c] == '0) begin
            s_d.cnt[c] = CNT_W'(HOLD_CYC);
            s_d.st[c]  = (c == CH_IN) ? TRC_HOLD : TRC_IDLE;
          end
        end
        TRC_HOLD: begin
          // Tape is stopped; read control stays up for the settle time.
          s_d.cnt[c] = s_q.cnt[c] - 1'b1;
          if (s_q.cnt[c] == '0) begin
            s_d.st[c] = TRC_IDLE;
            s_d.rd_op = 1'b0;
            if (s_q.rd_op && s_q.act) begin
              s_d.len[c] = 1'b1;
            end
          end
        end
        TRC_FMSTART: begin
          s_d.cnt[c] = s_q.cnt[c] - 1'b1;
          if (s_q.cnt[c] == '0) begin
            s_d.slot  = '0;
            s_d.st[c] = TRC_FMCHAR;
          end
        end
        TRC_FMCHAR: begin
          // Eight character slots; only the nonzero one reaches the tape.
          s_d.fm   = 1'b0;
          s_d.slot = s_q.slot + 1'b1;
          s_d.wch.data  = s_q.oword[47 - 6*s_q.slot -: 6];
          s_d.wch.valid = (s_q.oword[47 - 6*s_q.slot -: 6] != '0);
          if (s_q.slot == 3'd7) begin
            s_d.cnt[c] = CNT_W'(CHK_CYC);
            s_d.st[c]  = TRC_FMGAP;
          end
        end
        TRC_FMGAP: begin
          s_d.cnt[c] = s_q.cnt[c] - 1'b1;
          if (s_q.cnt[c] == '0) begin
            s_d.wch.valid = 1'b1;
            s_d.wch.data  = FM_CHAR;
            s_d.st[c]     = TRC_IDLE;
          end
        end
        default: begin
          s_d.st[c] = TRC_IDLE;
        end
      endcase
    end

    if (s_q.st[CH_IN] != TRC_IDLE && eof_detect) begin
      s_d.eof = 1'b1;
    end
    if (s_q.st[CH_OUT] != TRC_IDLE && eot_detect) begin
      s_d.eot = 1'b1;
    end

    // Character assembly, high position first; reading stops at record end.
    cv = s_q.pend | (s_q.st[CH_IN] == TRC_RUN && !s_q.eor[CH_IN] &&
                     rd_char_valid);
    cd = s_q.pend ? s_q.chr : char_register;
    if (cv) begin
      if (s_q.full && s_q.rd_op && !f_in_rdy) begin
        // Buffer path is full: keep the word and park the new character.
        s_d.pend = 1'b1;
        s_d.chr  = cd;
      end else begin
        f_in_v = s_q.full & s_q.rd_op;
        s_d.asm  = {s_q.asm[41:0], cd};
        s_d.pos  = s_q.pos + 1'b1;
        s_d.full = (s_q.pos == 3'd7);
        s_d.pend = 1'b0;
      end
    end else if (s_q.flush) begin
      // Final word, partial words shifted up to the high positions.
      f_in_d = s_q.full ? s_q.asm
                        : s_q.asm << (6'(CHAR_W) * (6'd8 - 6'(s_q.pos)));
      f_in_v = s_q.full | (s_q.pos != '0);
      if (f_in_rdy || !f_in_v) begin
        s_d.flush = 1'b0;
        s_d.full  = 1'b0;
        s_d.pos   = '0;
      end
    end

    // Input buffer: loaded only when cleared, emptied by resume.
    if (!s_q.rdy && f_out_v) begin
      s_d.ibuf = f_out_d;
      s_d.rdy  = 1'b1;
    end else if (s_q.rdy && s_q.res && !s_q.res_p) begin
      s_d.rdy  = 1'b0;
      s_d.ibuf = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the sense answer is only valid while a query is held.
  always_comb begin
    logic [1:0] cond;
    cond = '0;
    for (int c = 0; c < 2; c++) begin
      case (sense_code)
        SNS_READY: cond[c] = (s_q.st[c] == TRC_IDLE);
        SNS_PAR:   cond[c] = s_q.par[c];
        SNS_LEN:   cond[c] = s_q.len[c];
        SNS_EOF:   cond[c] = (c == CH_IN) ? s_q.eof : s_q.eot;
        default:   cond[c] = 1'b0;
      endcase
    end
    sense_resp = |(s_q.srq & cond);
  end

  // Motion runs from start through the stop delay or the file mark gap; backspace runs reversed.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign tape_motion[c]  = (s_q.st[c] != TRC_IDLE) &&
                             (s_q.st[c] != TRC_HOLD);
    assign tape_reverse[c] = tape_motion[c] & s_q.bksp[c];
    assign chan_busy[c]    = s_q.busy[c];
    assign intr_out[c]     = s_q.irq[c];
  end

  assign input_word_buffer = s_q.ibuf;
  assign data_ready        = s_q.rdy;
  assign wr_char           = s_q.wch;
  // No write current during an output backspace.
  assign write_current_en  = ~s_q.bksp[CH_OUT] &&
                             (s_q.st[CH_OUT] == TRC_FMCHAR ||
                              s_q.st[CH_OUT] == TRC_FMGAP ||
                              s_q.wch.valid);
  assign syn_buf_active    = s_q.fm | (s_q.st[CH_OUT] == TRC_FMCHAR);
  assign syn_out_ready     = (s_q.st[CH_OUT] == TRC_FMCHAR);
endmodule // trc_top

// file: trc_top_assertions.sv
// Concurrent checks on the ports of the tape read record control block.
`timescale 1ns/100ps
module trc_top_chk
  import trc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [47:0] input_word_buffer,
  input wire logic        data_ready,
  input wire logic        data_resume,
  input wire logic [1:0]  sense_req,
  input wire logic [1:0]  tape_motion,
  input wire logic [1:0]  tape_reverse,
  input wire logic [1:0]  chan_busy,
  input wire logic [1:0]  intr_out,
  input wire logic        write_current_en,
  input wire trc_pkg::trc_char_t wr_char
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt drops only after a sense query on its channel.
  property intr_held(int ch);
    $fell(intr_out[ch]) |-> ($past(sense_req[ch]) || $past(sense_req[ch], 2)
      || $past(sense_req[ch], 3) || $past(sense_req[ch], 4));
  endproperty

  // A waiting word stays put; an empty buffer reads as zero.
  buf_holds_a: assert property (data_ready && $past(data_ready) |->
    $stable(input_word_buffer)) else $error("buffer moved while ready");
  buf_clear_a: assert property (!data_ready |->
    input_word_buffer == 48'h0) else $error("buffer not cleared");
  ready_ack_a: assert property ($fell(data_ready) |->
    $past(data_resume)) else $error("ready fell without resume");
  // Backspace never hands data over and never writes.
  bk_no_data_a: assert property (tape_reverse[0] |->
    !$rose(data_ready)) else $error("data offered in backspace");
  bk_no_write_a: assert property (tape_reverse[1] |->
    !write_current_en) else $error("write current in backspace");
  fm_char_a: assert property (wr_char.valid |->
    wr_char.data == FM_CHAR) else $error("wrong file mark character");
  intr_on_a: assert property ($rose(intr_out[0]) |-> !chan_busy[0] &&
    ($past(chan_busy[0]) || $past(chan_busy[0], 2) || $past(chan_busy[0], 3)))
    else $error("interrupt without busy falling");
  intr_hold_a: assert property (intr_held(0))
    else $error("input interrupt dropped early");
  intr_hold_out_a: assert property (intr_held(1))
    else $error("output interrupt dropped early");
  busy_after_a: assert property ($fell(tape_motion[0]) |->
    chan_busy[0]) else $error("busy gone before motion stop");

  // Main scenarios reached.
  word_cov: cover property ($rose(data_ready));
  fm_cov: cover property (wr_char.valid);
  intr_cov: cover property ($rose(intr_out[0]));
endmodule // trc_top_chk

// file: trc_host_model.sv
// Behavioural host input channel taking words through ready and resume.
`timescale 1ns/100ps
module trc_host_model #(
  parameter int LAG = 0
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        data_ready,
  input  wire logic [47:0] input_word_buffer,
  output logic             data_resume
);
  logic [47:0] words [0:15];
  int          n_words = 0;

  initial data_resume = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Look just after the edge so the design's update has landed; a slow host
  // lag shows whether assembly keeps going while a word waits.
  always begin
    @(posedge clk);
    #1;
    if (!reset && data_ready === 1'b1) begin
      repeat (LAG) @(posedge clk);
      words[n_words] = input_word_buffer;
      n_words++;
      data_resume <= 1'b1;
      while (data_ready !== 1'b0) begin
        @(posedge clk);
        #1;
      end
      data_resume <= 1'b0;
    end
  end
endmodule // trc_host_model

// file: trc_top_tb.sv
// Self-checking bench for the tape read record control block.
`timescale 1ns/100ps
module trc_top_tb;
  import trc_pkg::*;
  localparam int STC = 20;
  localparam int RSC = 30;
  localparam int BSC = 40;
  localparam int HDC = 50;
  localparam int FMC = 25;
  logic        clk = 1'b0, reset = 1'b1;
  logic        read_sel = 1'b0, fmark_sel = 1'b0, in_buf_active = 1'b0;
  logic        rd_char_valid = 1'b0, reply_char_valid = 1'b0;
  logic        eof_detect = 1'b0, eot_detect = 1'b0;
  logic [1:0]  parity_err = 2'h0;
  logic [1:0]  bksp_sel = 2'h0, intr_sel = 2'h0, sense_req = 2'h0;
  logic [5:0]  char_register = 6'h0;
  logic [2:0]  sense_code = 3'h0;
  logic [47:0] input_word_buffer;
  logic        data_ready, sense_resp, write_current_en, data_resume;
  logic        syn_buf_active, syn_out_ready;
  logic [1:0]  tape_motion, tape_reverse, chan_busy, intr_out;
  trc_char_t   wr_char;
  int          bad_count = 0, n_checks = 0, cyc = 0;

  // Short delay counts keep the run brief; expectations use them.
  trc_top #(.START_CYC(STC), .RD_STOP_CYC(RSC), .BK_STOP_CYC(BSC),
    .HOLD_CYC(HDC), .FM_CYC(FMC)) dut_u (
    .clk(clk), .reset(reset), .read_sel(read_sel), .bksp_sel(bksp_sel),
    .fmark_sel(fmark_sel), .intr_sel(intr_sel),
    .rd_char_valid(rd_char_valid), .char_register(char_register),
    .reply_char_valid(reply_char_valid), .parity_err(parity_err),
    .eof_detect(eof_detect), .eot_detect(eot_detect),
    .data_resume(data_resume),
    .in_buf_active(in_buf_active), .sense_req(sense_req),
    .sense_code(sense_code), .input_word_buffer(input_word_buffer),
    .data_ready(data_ready), .sense_resp(sense_resp),
    .tape_motion(tape_motion), .tape_reverse(tape_reverse),
    .chan_busy(chan_busy), .intr_out(intr_out),
    .write_current_en(write_current_en), .wr_char(wr_char),
    .syn_buf_active(syn_buf_active), .syn_out_ready(syn_out_ready));

  trc_host_model #(.LAG(40)) host_u (.clk(clk), .reset(reset),
    .data_ready(data_ready), .input_word_buffer(input_word_buffer),
    .data_resume(data_resume));

  //////////////////////////////////////////////////////////////////////////////
  // Clock, and a watchdog that cuts a hang short.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input int t, input int lo, input int hi);
    check({47'h0, (t >= lo && t <= hi)}, 48'h1);
  endtask

  // Strobe order: read, file mark, backspace[1:0], interrupt[1:0].
  task automatic strobe(input logic [5:0] m);
    @(posedge clk);
    {read_sel, fmark_sel, bksp_sel, intr_sel} <= m;
    @(posedge clk);
    {read_sel, fmark_sel, bksp_sel, intr_sel} <= 6'h0;
  endtask

  // Characters 20 cycles apart, far inside the no-data gap.
  task automatic send(input int n, input logic [1:0] m);
    for (int i = 0; i < n; i++) begin
      repeat (19) @(posedge clk);
      rd_char_valid <= m[0];
      reply_char_valid <= m[1];
      char_register <= 6'(i + 1);
      @(posedge clk);
      {rd_char_valid, reply_char_valid} <= 2'h0;
    end
  endtask

  task automatic sense(input int ch, input logic [2:0] c, input logic e);
    @(posedge clk);
    sense_code <= c;
    sense_req[ch] <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check(48'(sense_resp), 48'(e));
    sense_req[ch] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  // Cycles until each channel's motion (sel 0) or busy (sel 1) drops.
  task automatic fall_times(input bit sel, output int f0, output int f1);
    int t;
    logic [1:0] s;
    t = 0;
    f0 = -1;
    f1 = -1;
    while (t < 4000 && (f0 < 0 || f1 < 0)) begin
      @(posedge clk);
      #1;
      t++;
      s = sel ? chan_busy : tape_motion;
      if (f0 < 0 && s[0] === 1'b0) f0 = t;
      if (f1 < 0 && s[1] === 1'b0) f1 = t;
    end
  endtask

  // First character lands in the top bits; a short last word has low zeros.
  function automatic logic [47:0] exp_word(input int w, input int n);
    logic [47:0] r;
    r = 48'h0;
    for (int k = 0; k < 8; k++)
      if (8 * w + k < n) r[47 - 6 * k -: 6] = 6'(8 * w + k + 1);
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // One read record with interrupt; act is buffer-active at the start and
  // keep holds it to the end.
  task automatic read_rec(input int n, input bit act, input bit keep);
    int f, m0, m1, b0, b1;
    f = host_u.n_words;
    in_buf_active <= act;
    strobe(6'h20);
    repeat (3) @(posedge clk);
    strobe(6'h01);
    repeat (STC) @(posedge clk);
    send(n, 2'h1);
    fall_times(1'b0, m0, m1);
    in_buf_active <= keep;
    fall_times(1'b1, b0, b1);
    in_range(m0, 798 + RSC, 808 + RSC);
    in_range(b0, HDC, HDC + 4);
    check(48'(host_u.n_words - f), 48'((n + 7) / 8));
    for (int w = 0; w < (n + 7) / 8; w++)
      check(host_u.words[f + w], exp_word(w, n));
    repeat (4) @(posedge clk);
    check(48'(intr_out[0]), 48'h1);
    sense(0, SNS_READY, 1'b1);
    check(48'(intr_out[0]), 48'h0);
  endtask

  task automatic fmark();
    int t, n, t0, t1;
    logic sb;
    t = 0;
    n = 0;
    t0 = 0;
    t1 = 0;
    sb = 1'b0;
    strobe(6'h10);
    strobe(6'h02);
    while (t < 4000 && !(n == 2 && chan_busy[1] === 1'b0)) begin
      @(posedge clk);
      #1;
      t++;
      if (syn_buf_active === 1'b1 && syn_out_ready === 1'b1) sb = 1'b1;
      if (wr_char.valid === 1'b1) begin
        check(48'(wr_char.data), 48'(FM_CHAR));
        check(48'(write_current_en), 48'h1);
        if (n == 0) t0 = t;
        else t1 = t;
        n++;
      end
    end
    in_range(n, 2, 2);
    in_range(t0, FMC + 4, FMC + 12);
    in_range(t1 - t0, CHK_CYC, CHK_CYC + 2);
    check(48'(sb), 48'h1);
    repeat (4) @(posedge clk);
    check(48'(intr_out[1]), 48'h1);
    sense(1, SNS_READY, 1'b1);
  endtask

  // Both channels back up over a record at once.
  task automatic bksp();
    int f, m0, m1, b0, b1;
    f = host_u.n_words;
    strobe(6'h0c);
    @(posedge clk);
    #1;
    check(48'(tape_reverse), 48'h3);
    // One cycle of error conditions while both channels are busy.
    parity_err <= 2'h1;
    {eof_detect, eot_detect} <= 2'h3;
    @(posedge clk);
    parity_err <= 2'h0;
    {eof_detect, eot_detect} <= 2'h0;
    repeat (STC) @(posedge clk);
    send(10, 2'h3);
    fall_times(1'b0, m0, m1);
    in_range(m0, 798 + RSC, 808 + RSC);
    in_range(m1, 798 + BSC, 808 + BSC);
    fall_times(1'b1, b0, b1);
    check(48'(host_u.n_words - f), 48'h0);
    sense(0, SNS_PAR, 1'b1);
    sense(0, SNS_LEN, 1'b1);
    sense(0, SNS_EOF, 1'b1);
    sense(1, SNS_EOF, 1'b1);
    sense(1, SNS_PAR, 1'b0);
  endtask

  // Main sequence: four reads, a file mark, a double backspace.
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    read_rec(19, 1'b1, 1'b0);
    sense(0, SNS_LEN, 1'b1);
    read_rec(16, 1'b1, 1'b0);
    sense(0, SNS_LEN, 1'b0);
    read_rec(8, 1'b1, 1'b1);
    sense(0, SNS_LEN, 1'b1);
    read_rec(16, 1'b0, 1'b0);
    sense(0, SNS_LEN, 1'b1);
    fmark();
    bksp();
    close_out();
  end
endmodule // trc_top_tb

bind trc_top trc_top_chk chk_u (.clk(clk), .reset(reset),
  .input_word_buffer(input_word_buffer), .data_ready(data_ready),
  .data_resume(data_resume), .sense_req(sense_req),
  .tape_motion(tape_motion), .tape_reverse(tape_reverse),
  .chan_busy(chan_busy), .intr_out(intr_out),
  .write_current_en(write_current_en), .wr_char(wr_char));
